//--- core/cpm_clk_gen.v
`include "cpm_defines.vh"

module cpm_clk_gen (
	// Clock and reset
	input wire core_clk_in,
	input wire rst_n_in,
	// Control
	input wire run_in,
	// Divided clocks
	output reg clk24_out,
	output reg clk12_out,
	output reg clk6_out
);

	localparam [`CPM_CLK_ACC_W-1:0] STEP = `CPM_CLK_STEP;
	localparam [`CPM_CLK_ACC_W-1:0] MODULUS = `CPM_CORE_MHZ;

	reg [`CPM_CLK_ACC_W-1:0] acc_q;
	wire [`CPM_CLK_ACC_W-1:0] acc_sum;
	wire wrap;

	// Fractional accumulator: average toggle rate is twice 24 MHz
	assign acc_sum = acc_q + STEP;
	assign wrap = (acc_sum >= MODULUS);

	always @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			acc_q <= 9'h000;
			clk24_out <= 1'b0;
			clk12_out <= 1'b0;
			clk6_out <= 1'b0;
		end
		else if (!run_in)
		begin
			// Stopped clocks park low
			acc_q <= 9'h000;
			clk24_out <= 1'b0;
			clk12_out <= 1'b0;
			clk6_out <= 1'b0;
		end
		else if (wrap)
		begin
			acc_q <= acc_sum - MODULUS;
			clk24_out <= ~clk24_out;
			if (!clk24_out)
			begin
				clk12_out <= ~clk12_out;
				if (!clk12_out)
				begin
					clk6_out <= ~clk6_out;
				end
			end
		end
		else
		begin
			acc_q <= acc_sum;
		end
	end

endmodule // cpm_clk_gen

//--- core/cpm_defines.vh
`ifndef CPM_DEFINES_VH
`define CPM_DEFINES_VH

// Option select codes, one per function
`define CPM_SEL_W 4
`define CPM_SEL_TRISTATE 4'h0
`define CPM_SEL_DRIVE1 4'h1
`define CPM_SEL_DRIVE0 4'h2
`define CPM_SEL_PWR_EN_N 4'h3
`define CPM_SEL_SUSPEND_N 4'h4
`define CPM_SEL_CLK24 4'h5
`define CPM_SEL_CLK12 4'h6
`define CPM_SEL_CLK6 4'h7
`define CPM_SEL_CHARGER 4'h8
`define CPM_SEL_CHARGER_N 4'h9
`define CPM_SEL_BB_WR_N 4'ha
`define CPM_SEL_BB_RD_N 4'hb
`define CPM_SEL_VBUS_SENSE 4'hc
`define CPM_SEL_SOF_TOGGLE 4'hd
`define CPM_SEL_KEEP_AWAKE_N 4'he

// Register bus
`define CPM_ADDR_W 8
`define CPM_DATA_W 32
`define CPM_REG_STATUS 8'h00
`define CPM_REG_CTRL 8'h04
`define CPM_REG_SELECT 8'h08
`define CPM_REG_SOF_COUNT 8'h0c

// Control register fields and reset value
`define CPM_CTRL_CLK_EN_BIT 0
`define CPM_CTRL_SOF_CLR_BIT 1
`define CPM_CTRL_RESET 1'b1

// Status register field positions
`define CPM_ST_CONFIGURED 0
`define CPM_ST_SUSPEND 1
`define CPM_ST_CHARGER 2
`define CPM_ST_VBUS 3
`define CPM_ST_INHIBIT 4
`define CPM_ST_SOF_TOGGLE 5
`define CPM_ST_PIN_A 6
`define CPM_ST_PIN_B 7
`define CPM_ST_PWR_EN_N 8
`define CPM_ST_SEL_VALID 9

// Clock generation: core rate and the fastest output, in MHz
`define CPM_CORE_MHZ 250
`define CPM_CLK24_MHZ 24
`define CPM_CLK_ACC_W 9
`define CPM_CLK_STEP (2 * `CPM_CLK24_MHZ)
`define CPM_SOF_CNT_W 16

`endif

//--- core/cpm_pin_mux.v
// Contract
// (R1) Both pins offer every function, one each
// (R2) Tri-state disables driver; constants drive 1/0
// (R3) Power enable low once configured, high suspended
// (R4) Suspend indicator low while suspended
// (R5) 24/12/6 MHz clocks, stopped during suspend
// (R6) Charger detect high when charger host seen
// (R7) Charger detect inverse is complement
// (R8) Bit-bang write strobe passed to pin
// (R9) Bit-bang read strobe passed to pin
// (R10) Supply-sense option reads pin as input
// (R11) Toggle output flips per start-of-frame
// (R12) Keep-awake input low blocks suspend when unplugged
// (R13) Selection latched after reset, held until reset
// (R14) Inputs undriven; unknown codes act tri-state
//
// The register offsets and strobed register access were decided locally.
`include "cpm_defines.vh"

module cpm_pin_mux (
	// Clock and reset
	input wire core_clk_in,
	input wire rst_n_in,
	// Nonvolatile selection
	input wire [`CPM_SEL_W-1:0] cfg_sel_a_in,
	input wire [`CPM_SEL_W-1:0] cfg_sel_b_in,
	// Internal USB state
	input wire usb_configured_in,
	input wire usb_suspend_in,
	input wire sof_pulse_in,
	input wire charger_detected_in,
	input wire bb_write_strobe_n_in,
	input wire bb_read_strobe_n_in,
	// Configurable pin A
	input wire option_pin_a_in,
	output reg option_pin_a_out,
	output reg option_pin_a_oe_out,
	// Configurable pin B
	input wire option_pin_b_in,
	output reg option_pin_b_out,
	output reg option_pin_b_oe_out,
	// Indications to the core
	output reg vbus_present_out,
	output reg suspend_inhibit_out,
	// Register port
	input wire [`CPM_ADDR_W-1:0] reg_addr_in,
	input wire [`CPM_DATA_W-1:0] reg_wdata_in,
	input wire reg_write_in,
	input wire reg_read_in,
	output reg [`CPM_DATA_W-1:0] reg_rdata_out
);

	localparam [1:0] PWR_UNCONF = 2'b00;
	localparam [1:0] PWR_ACTIVE = 2'b01;
	localparam [1:0] PWR_SUSPEND = 2'b10;

	reg [`CPM_SEL_W-1:0] sel_a_q;
	reg [`CPM_SEL_W-1:0] sel_b_q;
	reg sel_valid_q;
	reg [1:0] pwr_state_q;
	reg [1:0] pwr_state_d;
	reg pwr_en_n_q;
	reg sof_toggle_q;
	reg [`CPM_SOF_CNT_W-1:0] sof_count_q;
	reg clk_en_q;
	reg [15:0] fn_level;
	wire [1:0] drive_a;
	wire [1:0] drive_b;
	wire sof_clear;
	wire clk_run;
	wire clk24;
	wire clk12;
	wire clk6;
	wire vbus_level;
	wire inhibit_level;
	wire [`CPM_DATA_W-1:0] status_word;

	// True when the code is a recognised driven output
	function is_output;
		input [`CPM_SEL_W-1:0] sel;
		begin
			case (sel)
				`CPM_SEL_DRIVE1, `CPM_SEL_DRIVE0, `CPM_SEL_PWR_EN_N, `CPM_SEL_SUSPEND_N,
				`CPM_SEL_CLK24, `CPM_SEL_CLK12, `CPM_SEL_CLK6, `CPM_SEL_CHARGER,
				`CPM_SEL_CHARGER_N, `CPM_SEL_BB_WR_N, `CPM_SEL_BB_RD_N, `CPM_SEL_SOF_TOGGLE:
					is_output = 1'b1;
				default:
					is_output = 1'b0;
			endcase
		end
	endfunction

	// Write strobe aimed at the control register
	function ctrl_write;
		input write;
		input [`CPM_ADDR_W-1:0] addr;
		begin
			ctrl_write = write && (addr == `CPM_REG_CTRL);
		end
	endfunction

	// Level on a pin whose selection matches an input option
	function pin_match;
		input [`CPM_SEL_W-1:0] sel;
		input [`CPM_SEL_W-1:0] code;
		input level;
		begin
			pin_match = (sel == code) && level;
		end
	endfunction

	// Returns {output enable, level} for one pin
	function [1:0] pin_drive;
		input [`CPM_SEL_W-1:0] sel;
		input [15:0] levels;
		begin
			if (is_output(sel))
			begin
				pin_drive = {1'b1, levels[sel]};
			end
			else
			begin
				pin_drive = 2'b00;
			end
		end
	endfunction

	// Selection captured once, at the first edge after reset release
	always @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			sel_a_q <= `CPM_SEL_TRISTATE;
			sel_b_q <= `CPM_SEL_TRISTATE;
			sel_valid_q <= 1'b0;
		end
		else if (!sel_valid_q)
		begin
			sel_a_q <= cfg_sel_a_in; // [R13]
			sel_b_q <= cfg_sel_b_in; // [R13]
			sel_valid_q <= 1'b1;
		end
	end

	// Power enable tracker
	always @*
	begin
		pwr_state_d = pwr_state_q;
		case (pwr_state_q)
			PWR_UNCONF:
			begin
				if (usb_configured_in && !usb_suspend_in)
				begin
					pwr_state_d = PWR_ACTIVE;
				end
			end
			PWR_ACTIVE:
			begin
				if (usb_suspend_in)
				begin
					pwr_state_d = PWR_SUSPEND;
				end
				else if (!usb_configured_in)
				begin
					pwr_state_d = PWR_UNCONF;
				end
			end
			PWR_SUSPEND:
			begin
				if (!usb_suspend_in)
				begin
					pwr_state_d = usb_configured_in ? PWR_ACTIVE : PWR_UNCONF;
				end
			end
			default:
			begin
				pwr_state_d = PWR_UNCONF;
			end
		endcase
	end

	always @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			pwr_state_q <= PWR_UNCONF;
			pwr_en_n_q <= 1'b1;
		end
		else
		begin
			pwr_state_q <= pwr_state_d;
			// Low only while configured and awake
			pwr_en_n_q <= (pwr_state_d != PWR_ACTIVE); // [R3]
		end
	end

	// Start-of-frame toggle and count; a clear with a frame in the same cycle leaves count 1, toggle 1
	assign sof_clear = ctrl_write(reg_write_in, reg_addr_in) && reg_wdata_in[`CPM_CTRL_SOF_CLR_BIT];

	always @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			sof_toggle_q <= 1'b0;
			sof_count_q <= 16'h0000;
		end
		else if (sof_clear)
		begin
			sof_toggle_q <= sof_pulse_in;
			sof_count_q <= sof_pulse_in ? 16'h0001 : 16'h0000;
		end
		else if (sof_pulse_in)
		begin
			sof_toggle_q <= ~sof_toggle_q; // [R11]
			sof_count_q <= sof_count_q + 16'h0001;
		end
	end

	// Clock outputs stop in suspend or when software gates them
	assign clk_run = clk_en_q && !usb_suspend_in; // [R5]

	cpm_clk_gen u_clk_gen (
		.core_clk_in(core_clk_in),
		.rst_n_in(rst_n_in),
		.run_in(clk_run),
		.clk24_out(clk24),
		.clk12_out(clk12),
		.clk6_out(clk6)
	);

	// Level of every function, indexed by its select code
	always @*
	begin
		fn_level = 16'h0000;
		fn_level[`CPM_SEL_DRIVE1] = 1'b1; // [R2]
		fn_level[`CPM_SEL_DRIVE0] = 1'b0; // [R2]
		fn_level[`CPM_SEL_PWR_EN_N] = pwr_en_n_q; // [R3]
		fn_level[`CPM_SEL_SUSPEND_N] = ~usb_suspend_in; // [R4]
		fn_level[`CPM_SEL_CLK24] = clk24; // [R5]
		fn_level[`CPM_SEL_CLK12] = clk12; // [R5]
		fn_level[`CPM_SEL_CLK6] = clk6; // [R5]
		fn_level[`CPM_SEL_CHARGER] = charger_detected_in; // [R6]
		fn_level[`CPM_SEL_CHARGER_N] = ~charger_detected_in; // [R7]
		fn_level[`CPM_SEL_BB_WR_N] = bb_write_strobe_n_in; // [R8]
		fn_level[`CPM_SEL_BB_RD_N] = bb_read_strobe_n_in; // [R9]
		fn_level[`CPM_SEL_SOF_TOGGLE] = sof_toggle_q; // [R11]
	end

	// Same table for both pins; input and unknown codes leave the driver off
	assign drive_a = pin_drive(sel_a_q, fn_level); // [R1] [R2] [R14]
	assign drive_b = pin_drive(sel_b_q, fn_level); // [R1] [R2] [R14]

	always @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			option_pin_a_oe_out <= 1'b0;
			option_pin_a_out <= 1'b0;
			option_pin_b_oe_out <= 1'b0;
			option_pin_b_out <= 1'b0;
		end
		else
		begin
			option_pin_a_oe_out <= drive_a[1];
			option_pin_a_out <= drive_a[0];
			option_pin_b_oe_out <= drive_b[1];
			option_pin_b_out <= drive_b[0];
		end
	end

	// Input options: supply sense and keep-awake
	assign vbus_level = pin_match(sel_a_q, `CPM_SEL_VBUS_SENSE, option_pin_a_in) ||
		pin_match(sel_b_q, `CPM_SEL_VBUS_SENSE, option_pin_b_in); // [R10]
	assign inhibit_level = pin_match(sel_a_q, `CPM_SEL_KEEP_AWAKE_N, !option_pin_a_in) ||
		pin_match(sel_b_q, `CPM_SEL_KEEP_AWAKE_N, !option_pin_b_in); // [R12]

	always @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			vbus_present_out <= 1'b0;
			suspend_inhibit_out <= 1'b0;
		end
		else
		begin
			vbus_present_out <= vbus_level; // [R10]
			suspend_inhibit_out <= inhibit_level; // [R12]
		end
	end

	// Control register
	always @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			clk_en_q <= `CPM_CTRL_RESET;
		end
		else if (ctrl_write(reg_write_in, reg_addr_in))
		begin
			clk_en_q <= reg_wdata_in[`CPM_CTRL_CLK_EN_BIT];
		end
	end

	assign status_word = {
		22'h000000,
		sel_valid_q,
		pwr_en_n_q,
		option_pin_b_in,
		option_pin_a_in,
		sof_toggle_q,
		suspend_inhibit_out,
		vbus_present_out,
		charger_detected_in,
		usb_suspend_in,
		usb_configured_in
	};

	// Read data stand for the one cycle after the strobe, zero otherwise
	always @(posedge core_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			reg_rdata_out <= 32'h00000000;
		end
		else if (reg_read_in)
		begin
			case (reg_addr_in)
				`CPM_REG_STATUS:
					reg_rdata_out <= status_word;
				`CPM_REG_CTRL:
					reg_rdata_out <= {31'h00000000, clk_en_q};
				`CPM_REG_SELECT:
					reg_rdata_out <= {24'h000000, sel_b_q, sel_a_q};
				`CPM_REG_SOF_COUNT:
					reg_rdata_out <= {16'h0000, sof_count_q};
				default:
					reg_rdata_out <= 32'h00000000;
			endcase
		end
		else
		begin
			reg_rdata_out <= 32'h00000000;
		end
	end

endmodule // cpm_pin_mux

//--- test/cpm_pin_mux_asserts.sv
`include "cpm_defines.vh"

module cpm_pin_mux_asserts (
	// Watched ports
	input wire core_clk_in,
	input wire rst_n_in,
	input wire [3:0] cfg_sel_a_in,
	input wire [3:0] cfg_sel_b_in,
	input wire usb_suspend_in,
	input wire sof_pulse_in,
	input wire charger_detected_in,
	input wire bb_write_strobe_n_in,
	input wire bb_read_strobe_n_in,
	input wire option_pin_a_out,
	input wire option_pin_a_oe_out,
	input wire option_pin_b_out,
	input wire option_pin_b_oe_out,
	input wire [7:0] reg_addr_in,
	input wire reg_read_in,
	input wire [31:0] reg_rdata_out
);
	reg [3:0] sa_q;
	reg [3:0] sb_q;
	reg [1:0] ph_q;
	wire up = ph_q == 2'h3;
	// Own copy of the selection taken after reset
	always @(posedge core_clk_in or negedge rst_n_in)
		if (!rst_n_in)
			ph_q <= 2'h0;
		else if (!up)
			ph_q <= ph_q + 2'h1;
	always @(posedge core_clk_in)
		if (ph_q == 2'h0)
			{sb_q, sa_q} <= {cfg_sel_b_in, cfg_sel_a_in};
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);
	sequence frame_s;
		up && sa_q == `CPM_SEL_SOF_TOGGLE && sof_pulse_in;
	endsequence
	sequence asleep_s;
		usb_suspend_in [*3];
	endsequence
	drive_one_a: assert property (up && sa_q == `CPM_SEL_DRIVE1 |-> option_pin_a_out && option_pin_a_oe_out)
		else $error("pin a not high");
	drive_zero_a: assert property (up && sb_q == `CPM_SEL_DRIVE0 |-> !option_pin_b_out && option_pin_b_oe_out)
		else $error("pin b not low");
	tri_off_a: assert property (up && sa_q inside {`CPM_SEL_TRISTATE, `CPM_SEL_VBUS_SENSE, 4'hf} |-> !option_pin_a_oe_out)
		else $error("pin a driven");
	charger_level_a: assert property (up && sa_q == `CPM_SEL_CHARGER |-> option_pin_a_out == $past(charger_detected_in))
		else $error("charger level wrong");
	charger_inv_a: assert property (up && sb_q == `CPM_SEL_CHARGER_N |-> option_pin_b_out != $past(charger_detected_in))
		else $error("charger inverse wrong");
	sleep_ind_a: assert property (up && sb_q == `CPM_SEL_SUSPEND_N |-> option_pin_b_out != $past(usb_suspend_in))
		else $error("suspend level wrong");
	write_strobe_a: assert property (up && sa_q == `CPM_SEL_BB_WR_N |-> option_pin_a_out == $past(bb_write_strobe_n_in))
		else $error("write strobe wrong");
	read_strobe_a: assert property (up && sb_q == `CPM_SEL_BB_RD_N |-> option_pin_b_out == $past(bb_read_strobe_n_in))
		else $error("read strobe wrong");
	sof_flip_a: assert property (frame_s |-> ##2 option_pin_a_out != $past(option_pin_a_out))
		else $error("no toggle on frame");
	power_off_a: assert property (up && sa_q == `CPM_SEL_PWR_EN_N ##0 asleep_s |-> option_pin_a_out)
		else $error("power enable low in suspend");
	clock_park_a: assert property (up && sa_q inside {[`CPM_SEL_CLK24:`CPM_SEL_CLK6]} ##0 asleep_s |-> !option_pin_a_out)
		else $error("clock runs in suspend");
	select_held_a: assert property (up && reg_read_in && reg_addr_in == `CPM_REG_SELECT |=> reg_rdata_out == {sb_q, sa_q})
		else $error("selection changed");
endmodule // cpm_pin_mux_asserts

bind cpm_pin_mux cpm_pin_mux_asserts u_chk (.*);

//--- test/cpm_pin_partner.sv
module cpm_pin_partner (
	// Clock
	input wire logic core_clk_in,
	// Design pin drive
	input wire logic a_out_in,
	input wire logic a_oe_in,
	input wire logic b_out_in,
	input wire logic b_oe_in,
	// Far-side drive
	input wire logic ext_en_in,
	input wire logic ext_a_in,
	input wire logic ext_b_in,
	// Resolved pin levels
	output logic pin_a_out,
	output logic pin_b_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic flip_q = 1'b0;
	// Floating wire wanders so a stale level never passes
	always @(posedge core_clk_in)
		flip_q <= !flip_q;
	assign pin_a_out = a_oe_in ? a_out_in : ext_en_in ? ext_a_in : flip_q;
	assign pin_b_out = b_oe_in ? b_out_in : ext_en_in ? ext_b_in : !flip_q;
endmodule // cpm_pin_partner

//--- test/test_control_pin_option_mux.sv
`include "cpm_defines.vh"

module test_control_pin_option_mux;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk_in, rst_n_in, usb_configured_in, usb_suspend_in, sof_pulse_in, charger_detected_in;
	logic bb_write_strobe_n_in, bb_read_strobe_n_in, reg_write_in, reg_read_in, ext_en, ext_a, ext_b;
	logic [3:0] cfg_sel_a_in, cfg_sel_b_in;
	logic [7:0] reg_addr_in;
	logic [31:0] reg_wdata_in, rd_q;
	wire [31:0] reg_rdata_out;
	wire option_pin_a_in, option_pin_b_in, option_pin_a_out, option_pin_b_out;
	wire option_pin_a_oe_out, option_pin_b_oe_out, vbus_present_out, suspend_inhibit_out;
	int mismatches, checks_done, cyc, n, p;
	cpm_pin_mux u_dut (.*);
	cpm_pin_partner u_far (.core_clk_in, .a_out_in(option_pin_a_out), .a_oe_in(option_pin_a_oe_out),
		.b_out_in(option_pin_b_out), .b_oe_in(option_pin_b_oe_out), .ext_en_in(ext_en), .ext_a_in(ext_a),
		.ext_b_in(ext_b), .pin_a_out(option_pin_a_in), .pin_b_out(option_pin_b_in));
	initial
	begin
		core_clk_in = 1'b0;
		forever #2 core_clk_in = ~core_clk_in;
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task wrap_up();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task tick(input int k);
		repeat (k) @(posedge core_clk_in);
		@(negedge core_clk_in);
	endtask
	task automatic boot(input logic [3:0] sa, input logic [3:0] sb);
		@(posedge core_clk_in);
		rst_n_in <= 1'b0;
		cfg_sel_a_in <= sa;
		cfg_sel_b_in <= sb;
		repeat (4) @(posedge core_clk_in);
		rst_n_in <= 1'b1;
		tick(4);
	endtask
	task automatic rw(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_write_in <= wr;
		reg_read_in <= !wr;
		@(posedge core_clk_in);
		{reg_write_in, reg_read_in} <= 2'b00;
		@(negedge core_clk_in);
		rd_q = reg_rdata_out;
	endtask
	task count(input int k);
		n = 0;
		p = 0;
		repeat (k)
		begin
			@(negedge core_clk_in);
			n += option_pin_a_out && !p;
			p = option_pin_a_out;
		end
	endtask
	task t_fixed();
		boot(`CPM_SEL_DRIVE1, `CPM_SEL_DRIVE0);
		chk("a", {option_pin_a_oe_out, option_pin_a_out}, 32'h3);
		chk("b", {option_pin_b_oe_out, option_pin_b_out}, 32'h2);
		@(posedge core_clk_in);
		{cfg_sel_b_in, cfg_sel_a_in} <= 8'h00;
		tick(3);
		chk("held", {option_pin_a_oe_out, option_pin_a_out}, 32'h3);
		rw(1'b0, `CPM_REG_SELECT, 32'h0);
		chk("sel", rd_q, 32'h21);
		boot(`CPM_SEL_TRISTATE, 4'hf);
		chk("oe", {option_pin_a_oe_out, option_pin_b_oe_out}, 32'h0);
		$display("done fixed");
	endtask
	task t_usb();
		boot(`CPM_SEL_PWR_EN_N, `CPM_SEL_SUSPEND_N);
		chk("pwr", option_pin_a_out, 32'h1);
		for (int v = 0; v < 2; v++)
		begin
			@(posedge core_clk_in);
			usb_configured_in <= 1'b1;
			usb_suspend_in <= v[0];
			tick(3);
			chk("pwr", option_pin_a_out, v);
			chk("slp", option_pin_b_out, !v);
		end
		@(posedge core_clk_in);
		usb_suspend_in <= 1'b0;
		$display("done usb");
	endtask
	task t_levels();
		boot(`CPM_SEL_CHARGER, `CPM_SEL_CHARGER_N);
		for (int v = 1; v >= 0; v--)
		begin
			@(posedge core_clk_in);
			charger_detected_in <= v[0];
			tick(2);
			chk("chg", option_pin_a_out, v);
			chk("chgn", option_pin_b_out, !v);
		end
		boot(`CPM_SEL_BB_WR_N, `CPM_SEL_BB_RD_N);
		for (int v = 0; v < 2; v++)
		begin
			@(posedge core_clk_in);
			bb_write_strobe_n_in <= v[0];
			bb_read_strobe_n_in <= !v[0];
			tick(2);
			chk("wr", option_pin_a_out, v);
			chk("rd", option_pin_b_out, !v);
		end
		$display("done levels");
	endtask
	task t_inputs();
		boot(`CPM_SEL_VBUS_SENSE, `CPM_SEL_KEEP_AWAKE_N);
		for (int v = 0; v < 2; v++)
		begin
			@(posedge core_clk_in);
			ext_en <= 1'b1;
			ext_a <= v[0];
			ext_b <= !v[0];
			tick(3);
			chk("vbus", vbus_present_out, v);
			chk("awake", suspend_inhibit_out, v);
			chk("oe", {option_pin_a_oe_out, option_pin_b_oe_out}, 32'h0);
		end
		rw(1'b0, `CPM_REG_STATUS, 32'h0);
		chk("status", rd_q, 32'h259);
		$display("done inputs");
	endtask
	task t_frame();
		boot(`CPM_SEL_SOF_TOGGLE, `CPM_SEL_TRISTATE);
		rw(1'b0, `CPM_REG_CTRL, 32'h0);
		chk("ctrl", rd_q, 32'h1);
		@(posedge core_clk_in);
		sof_pulse_in <= 1'b1;
		@(posedge core_clk_in);
		sof_pulse_in <= 1'b0;
		tick(3);
		chk("sof", option_pin_a_out, 32'h1);
		rw(1'b0, `CPM_REG_SOF_COUNT, 32'h0);
		chk("cnt", rd_q, 32'h1);
		rw(1'b1, `CPM_REG_CTRL, 32'h3);
		rw(1'b0, `CPM_REG_SOF_COUNT, 32'h0);
		chk("clr", rd_q, 32'h0);
		rw(1'b0, 8'h10, 32'h0);
		chk("gap", rd_q, 32'h0);
		chk("sof", option_pin_a_out, 32'h0);
		$display("done frame");
	endtask
	task t_clock();
		for (int i = 0; i < 3; i++)
		begin
			boot(`CPM_SEL_CLK24 + i[3:0], `CPM_SEL_TRISTATE);
			count(250);
			chk("clk", n >= (24 >> i) - 1 && n <= (24 >> i) + 1, 32'h1);
			@(posedge core_clk_in);
			usb_suspend_in <= 1'b1;
			tick(3);
			count(40);
			chk("stop", n, 32'h0);
			@(posedge core_clk_in);
			usb_suspend_in <= 1'b0;
		end
		rw(1'b1, `CPM_REG_CTRL, 32'h0);
		tick(2);
		count(40);
		chk("off", n, 32'h0);
		$display("done clock");
	endtask
	always @(posedge core_clk_in)
	begin
		cyc++;
		if (cyc > 5000)
		begin
			mismatches++;
			wrap_up();
		end
	end
	initial
	begin
		{rst_n_in, usb_configured_in, usb_suspend_in, sof_pulse_in, charger_detected_in} = 5'h00;
		{bb_write_strobe_n_in, bb_read_strobe_n_in, reg_write_in, reg_read_in} = 4'hc;
		{ext_en, ext_a, ext_b, cfg_sel_a_in, cfg_sel_b_in, reg_addr_in} = 19'h0;
		reg_wdata_in = 32'h0;
		t_fixed();
		t_usb();
		t_levels();
		t_inputs();
		t_frame();
		t_clock();
		wrap_up();
	end
endmodule // test_control_pin_option_mux
